// ===== design/servo_warning_code_encoder.sv
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module servo_warning_code_encoder
   import warn_pkg::*;
#(
   parameter int DEV_WIDTH = DEV_W,
   parameter logic [OPT_N-1:0] OPT_EXPECT = {OPT_N{1'b0}}
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [DEV_WIDTH-1:0] position_deviation,
   input wire logic servo_on,
   input wire logic vib_detect,
   input wire cond_t cond_in,
   input wire option_t option_in,
   input wire logic [MTYPE_W-1:0] motor_type,
   input wire logic [MTYPE_W-1:0] stored_motor_type,
   input wire logic stored_opt_alarm,
   input wire logic stored_mtype_alarm,
   output logic code_out_bit_a,
   output logic code_out_bit_b,
   output logic code_out_bit_c,
   output logic warning_active,
   output logic vibration_alarm,
   output logic option_alarm,
   output logic motor_type_alarm,
   output logic [MTYPE_W-1:0] motor_type_save
);

   logic [3:0] ctrl;
   logic [LVL_W-1:0] excess_position_error_level;
   logic [PCT_W-1:0] deviation_warning_percent;
   logic [LVL_W-1:0] servo_on_deviation_level;
   logic [PCT_W-1:0] servo_on_deviation_warning_percent;
   cond_t c_m;
   cond_t c_s;
   option_t o_m;
   option_t o_s;
   logic servo_on_m;
   logic servo_on_s;
   logic servo_on_d;
   logic vib_m;
   logic vib_s;
   logic [WARN_N-1:0] raw;
   logic [WARN_N-1:0] warn;
   logic son_warn;
   logic [OPT_N-1:0] opt_latched;
   logic [2:0] next_code;
   logic next_active;
   mt_state_t mt_state;
   logic wr;
   logic rd;
   logic [31:0] next_prdata;
   logic opt_clr;
   logic mtype_clr;
   logic alm_rst;
   logic vib_hit;
   logic opt_stored;

   // Compare dev*100 against level*percent, avoids a divider
   function automatic logic over_limit(input logic [DEV_WIDTH-1:0] dev,
                                       input logic [LVL_W-1:0] lvl,
                                       input logic [PCT_W-1:0] pct);
      logic [DEV_WIDTH+PCT_W-1:0] lhs;
      logic [LVL_W+PCT_W-1:0] rhs;
      lhs = dev * PCT_DIV;
      rhs = lvl * pct;
      over_limit = (DEV_WIDTH + PCT_W)'(lhs)
                   > (DEV_WIDTH + PCT_W + LVL_W)'(rhs);
   endfunction

   // Pins from the drive's sensors cross two stages first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c_m <= '0;
         c_s <= '0;
         o_m <= '0;
         o_s <= '0;
         servo_on_m <= 1'b0;
         servo_on_s <= 1'b0;
         servo_on_d <= 1'b0;
         vib_m <= 1'b0;
         vib_s <= 1'b0;
      end else begin
         c_m <= cond_in;
         c_s <= c_m;
         o_m <= option_in;
         o_s <= o_m;
         servo_on_m <= servo_on;
         servo_on_s <= servo_on_m;
         servo_on_d <= servo_on_s;
         vib_m <= vib_detect;
         vib_s <= vib_m;
      end
   end

   // Vibration may come from its own pin or from the condition word
   assign vib_hit = vib_s || c_s.vibration;

   // Writes act at the access edge; reads are captured at setup
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   // Dedicated resets are blocked while writes are prohibited
   assign opt_clr = wr && paddr == ADDR_UTIL && pwdata[UTIL_OPT_CLR]
                    && !ctrl[CTRL_WR_PROHIBIT];
   assign mtype_clr = wr && paddr == ADDR_UTIL && pwdata[UTIL_MTYPE_CLR]
                      && !ctrl[CTRL_WR_PROHIBIT];
   assign alm_rst = wr && paddr == ADDR_UTIL && pwdata[UTIL_ALM_RST];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
         excess_position_error_level <= '1;
         deviation_warning_percent <= PCT_DIV;
         servo_on_deviation_level <= '1;
         servo_on_deviation_warning_percent <= PCT_DIV;
      end else if (wr) begin
         unique case (paddr)
            ADDR_CTRL: ctrl <= pwdata[3:0];
            ADDR_DEV_LVL: begin
               excess_position_error_level <= pwdata[LVL_W-1:0];
               deviation_warning_percent <= pwdata[31:LVL_W];
            end
            ADDR_SON_LVL: begin
               servo_on_deviation_level <= pwdata[LVL_W-1:0];
               servo_on_deviation_warning_percent <= pwdata[31:LVL_W];
            end
            default: ;
         endcase
      end
   end

   // Servo-on check samples only the turn-on edge; the alarm reset
   // or servo off clears it, since the edge never repeats by itself
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         son_warn <= 1'b0;
      end else if (servo_on_s && !servo_on_d
                   && over_limit(position_deviation,
                                 servo_on_deviation_level,
                                 servo_on_deviation_warning_percent)) begin
         son_warn <= 1'b1;
      end else if (alm_rst || !servo_on_s) begin
         son_warn <= 1'b0;
      end
   end

   always_comb begin
      raw = '0;
      raw[W_DEV] = over_limit(position_deviation,
                              excess_position_error_level,
                              deviation_warning_percent);
      raw[W_SON] = son_warn;
      raw[W_OVL] = c_s.overload;
      raw[W_VIB] = vib_hit && !ctrl[CTRL_VIB_ALARM];
      raw[W_TCTL] = c_s.temp_ctrl;
      raw[W_TPWR] = c_s.temp_power;
      raw[W_REGEN] = c_s.regen_overload;
      raw[W_DB] = c_s.brake_overload;
      raw[W_FAN] = c_s.fan_stopped;
      raw[W_BAT] = c_s.battery_low;
      raw[W_PRM] = c_s.restart_params;
      raw[W_RIP] = c_s.ripple_mismatch;
      raw[W_UV] = c_s.undervoltage;
      raw[W_OT] = c_s.overtravel && servo_on_s;
      raw[W_PM] = c_s.part_worn;
   end

   // Undervoltage survives the no-detect setting
   always_comb begin
      warn = raw;
      if (ctrl[CTRL_NO_DETECT]) begin
         warn = '0;
         warn[W_UV] = raw[W_UV];
      end
   end

   // Lowest index wins when several warnings stand at once
   always_comb begin
      next_code = CODE_IDLE;
      next_active = 1'b0;
      for (int i = WARN_N - 1; i >= 0; i--) begin
         if (warn[i]) begin
            next_active = 1'b1;
            unique case (i)
               W_DEV, W_SON: next_code = CODE_HHH;
               W_OVL, W_VIB: next_code = CODE_LHH;
               W_BAT: next_code = CODE_LLH;
               W_PRM, W_RIP: next_code = CODE_HHL;
               W_UV: next_code = CODE_LLL;
               W_OT: next_code = CODE_HLL;
               default: next_code = CODE_HLH;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_out_bit_a <= 1'b0;
         code_out_bit_b <= 1'b0;
         code_out_bit_c <= 1'b0;
         warning_active <= 1'b0;
         vibration_alarm <= 1'b0;
      end else begin
         warning_active <= next_active;
         if (ctrl[CTRL_CODE_SEL] && next_active) begin
            code_out_bit_a <= next_code[2];
            code_out_bit_b <= next_code[1];
            code_out_bit_c <= next_code[0];
         end else begin
            code_out_bit_a <= 1'b0;
            code_out_bit_b <= 1'b0;
            code_out_bit_c <= 1'b0;
         end
         if (vib_hit && ctrl[CTRL_VIB_ALARM]) begin
            vibration_alarm <= 1'b1;
         end else if (alm_rst) begin
            vibration_alarm <= 1'b0;
         end
      end
   end

   // Option alarms: set beats clear; a standing hardware error cannot be cleared
   // Checks wait for the run state so the reset value of the
   // synchroniser is never mistaken for a missing module
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_latched <= '0;
         opt_stored <= 1'b0;
         option_alarm <= 1'b0;
      end else begin
         for (int i = 0; i < OPT_N; i++) begin
            if (mt_state == MT_RUN
                && (o_s.hw_error[i]
                    || o_s.present[i] != OPT_EXPECT[i]
                    || (o_s.present[i] && o_s.model_bad[i]))) begin
               opt_latched[i] <= 1'b1;
            end else if (opt_clr) begin
               opt_latched[i] <= 1'b0;
            end
         end
         // A stored alarm is taken once at start-up; after that only
         // its own reset clears it, like a freshly found one
         if (mt_state == MT_LOAD && stored_opt_alarm) begin
            opt_stored <= 1'b1;
         end else if (opt_clr) begin
            opt_stored <= 1'b0;
         end
         option_alarm <= |opt_latched || |o_s.hw_error
                         || opt_stored;
      end
   end

   // Motor type compared once after reset against the saved type
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mt_state <= MT_IDLE;
         motor_type_alarm <= 1'b0;
         motor_type_save <= '0;
      end else begin
         unique case (mt_state)
            MT_IDLE: mt_state <= MT_LOAD;
            MT_LOAD: begin
               mt_state <= MT_RUN;
               motor_type_save <= stored_motor_type;
               if (motor_type != stored_motor_type
                   || stored_mtype_alarm) begin
                  motor_type_alarm <= 1'b1;
               end
            end
            MT_RUN: begin
               if (mtype_clr) begin
                  motor_type_alarm <= 1'b0;
                  motor_type_save <= motor_type;
               end
            end
            default: mt_state <= MT_IDLE;
         endcase
      end
   end

   always_comb begin
      next_prdata = '0;
      unique case (paddr)
         ADDR_CTRL: next_prdata[3:0] = ctrl;
         ADDR_DEV_LVL: next_prdata = {deviation_warning_percent,
                                      excess_position_error_level};
         ADDR_SON_LVL: next_prdata = {servo_on_deviation_warning_percent,
                                      servo_on_deviation_level};
         ADDR_WARN: next_prdata[WARN_N-1:0] = warn;
         ADDR_CODE: next_prdata[3:0] = {next_active, next_code};
         ADDR_OPT: next_prdata[2*OPT_N-1:0] = {o_s.hw_error, opt_latched};
         ADDR_MTYPE: next_prdata[MTYPE_W:0] = {motor_type_alarm,
                                               motor_type};
         default: next_prdata = '0;
      endcase
   end

   // Every access completes in its first access cycle, with no wait cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && paddr > ADDR_UTIL;
         // A refused access loads zero so no stale word rides with it
         if (rd || (psel && !penable && paddr > ADDR_UTIL)) begin
            prdata <= next_prdata;
         end
      end
   end

endmodule

// ===== inc/warn_pkg.sv
package warn_pkg;
   localparam int DEV_W = 32;
   localparam int PCT_W = 8;
   localparam int LVL_W = 24;
   localparam int OPT_N = 4;
   localparam int MTYPE_W = 8;
   localparam int WARN_N = 15;
   localparam logic [7:0] PCT_DIV = 8'h64;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DEV_LVL = 8'h04;
   localparam logic [7:0] ADDR_SON_LVL = 8'h08;
   localparam logic [7:0] ADDR_WARN = 8'h0C;
   localparam logic [7:0] ADDR_CODE = 8'h10;
   localparam logic [7:0] ADDR_OPT = 8'h14;
   localparam logic [7:0] ADDR_MTYPE = 8'h18;
   localparam logic [7:0] ADDR_UTIL = 8'h1C;
   // Control and utility register fields
   localparam int CTRL_CODE_SEL = 0;
   localparam int CTRL_NO_DETECT = 1;
   localparam int CTRL_VIB_ALARM = 2;
   localparam int CTRL_WR_PROHIBIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam int UTIL_OPT_CLR = 0;
   localparam int UTIL_MTYPE_CLR = 1;
   localparam int UTIL_ALM_RST = 2;
   // Warning index order, first has highest output priority
   localparam int W_DEV = 0;
   localparam int W_SON = 1;
   localparam int W_OVL = 2;
   localparam int W_VIB = 3;
   localparam int W_TCTL = 4;
   localparam int W_TPWR = 5;
   localparam int W_REGEN = 6;
   localparam int W_DB = 7;
   localparam int W_FAN = 8;
   localparam int W_BAT = 9;
   localparam int W_PRM = 10;
   localparam int W_RIP = 11;
   localparam int W_UV = 12;
   localparam int W_OT = 13;
   localparam int W_PM = 14;
   localparam logic [2:0] CODE_HHH = 3'h7;
   localparam logic [2:0] CODE_LHH = 3'h3;
   localparam logic [2:0] CODE_HLH = 3'h5;
   localparam logic [2:0] CODE_LLH = 3'h1;
   localparam logic [2:0] CODE_HHL = 3'h6;
   localparam logic [2:0] CODE_LLL = 3'h0;
   localparam logic [2:0] CODE_HLL = 3'h4;
   localparam logic [2:0] CODE_IDLE = 3'h7;

   typedef struct packed {
      logic overload;
      logic vibration;
      logic temp_ctrl;
      logic temp_power;
      logic regen_overload;
      logic brake_overload;
      logic fan_stopped;
      logic battery_low;
      logic restart_params;
      logic ripple_mismatch;
      logic undervoltage;
      logic overtravel;
      logic part_worn;
   } cond_t;

   typedef struct packed {
      logic [OPT_N-1:0] present;
      logic [OPT_N-1:0] model_bad;
      logic [OPT_N-1:0] hw_error;
   } option_t;

   typedef enum logic [1:0] {
      MT_IDLE = 2'b00,
      MT_LOAD = 2'b01,
      MT_RUN = 2'b11
   } mt_state_t;
endpackage

// ===== test/warn_chk.sv
`timescale 1ns/10ps
module warn_chk
   import warn_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire option_t option_in,
   input wire logic code_out_bit_a,
   input wire logic code_out_bit_b,
   input wire logic code_out_bit_c,
   input wire logic warning_active,
   input wire logic vibration_alarm,
   input wire logic option_alarm,
   input wire logic motor_type_alarm
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic util_wr = psel && penable && pwrite && paddr == ADDR_UTIL;
   wire logic opt_clr = util_wr && pwdata[UTIL_OPT_CLR];
   wire logic mt_clr = util_wr && pwdata[UTIL_MTYPE_CLR];
   wire logic alm_clr = util_wr && pwdata[UTIL_ALM_RST];
   wire logic [2:0] code = {code_out_bit_a, code_out_bit_b, code_out_bit_c};
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   a_setup_answer: assert property (psel && !penable |=> pready)
      else $error("no answer in the first access cycle");
   a_slverr_range: assert property (pready |-> pslverr == (paddr > 8'h1C))
      else $error("pslverr does not match the address range");
   a_unmapped_zero: assert property (pready && pslverr |-> prdata == '0)
      else $error("refused access returned data");
   a_idle_code: assert property (!warning_active |-> code == 3'h0)
      else $error("code lines driven with no warning");
   a_opt_clear: assert property ($fell(option_alarm) |->
      $past(opt_clr) || $past(opt_clr, 2))
      else $error("option alarm dropped without its reset");
   a_mtype_clear: assert property ($fell(motor_type_alarm) |->
      $past(mt_clr) || $past(mt_clr, 2))
      else $error("motor type alarm dropped without its reset");
   a_vib_clear: assert property ($fell(vibration_alarm) |->
      $past(alm_clr) || $past(alm_clr, 2))
      else $error("vibration alarm dropped without a reset");
   a_hw_error: assert property ((|option_in.hw_error)[*5] |-> option_alarm)
      else $error("hardware error not reported");
endmodule

bind servo_warning_code_encoder warn_chk chk_u (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .option_in, .code_out_bit_a, .code_out_bit_b, .code_out_bit_c,
   .warning_active, .vibration_alarm, .option_alarm, .motor_type_alarm);

// ===== test/host_code_model.sv
`timescale 1ns/10ps
module host_code_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic code_out_bit_a,
   input wire logic code_out_bit_b,
   input wire logic code_out_bit_c,
   output logic [2:0] host_code
);
   // Host latches the code lines once a cycle, so it lags them by one edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_code <= 3'h0;
      end else begin
         host_code <= {code_out_bit_a, code_out_bit_b, code_out_bit_c};
      end
   end
endmodule

// ===== test/servo_warning_code_encoder_tb.sv
`timescale 1ns/10ps
module servo_warning_code_encoder_tb
   import warn_pkg::*;
   ;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, position_deviation;
   logic servo_on, vib_detect, stored_opt_alarm, stored_mtype_alarm;
   cond_t cond_in;
   option_t option_in;
   logic [MTYPE_W-1:0] motor_type, stored_motor_type, motor_type_save;
   logic code_out_bit_a, code_out_bit_b, code_out_bit_c, warning_active;
   logic vibration_alarm, option_alarm, motor_type_alarm;
   logic [2:0] host_code;
   int fail_count = 0, checked = 0, cyc = 0;
   // Expected code for each condition bit, from the top bit down
   logic [2:0] row_code [13] = '{CODE_LHH, CODE_LHH, CODE_HLH, CODE_HLH,
      CODE_HLH, CODE_HLH, CODE_HLH, CODE_LLH, CODE_HHL, CODE_HHL, CODE_LLL,
      CODE_HLL, CODE_HLH};

   servo_warning_code_encoder #(.OPT_EXPECT(4'h1)) dut_u (.pclk, .presetn,
      .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .position_deviation, .servo_on, .vib_detect, .cond_in, .option_in,
      .motor_type, .stored_motor_type, .stored_opt_alarm,
      .stored_mtype_alarm, .code_out_bit_a, .code_out_bit_b, .code_out_bit_c,
      .warning_active, .vibration_alarm, .option_alarm, .motor_type_alarm,
      .motor_type_save);
   host_code_model host_u (.pclk, .presetn, .code_out_bit_a,
      .code_out_bit_b, .code_out_bit_c, .host_code);

   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end

   task automatic end_sim;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Slow sensor paths pass two sync stages, so settle waits are generous
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         end_sim;
      end
   end

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic ut(input logic [31:0] d);
      xfer(1'h1, ADDR_UTIL, d);
      wt(2);
   endtask

   initial begin
      {presetn, psel, penable, pwrite, vib_detect} = '0;
      {stored_opt_alarm, stored_mtype_alarm} = '0;
      paddr = '0;
      pwdata = '0;
      position_deviation = '0;
      servo_on = 1'h1;
      cond_in = '0;
      option_in = '0;
      option_in.present = 4'h1;
      motor_type = 8'h05;
      stored_motor_type = 8'h05;
      wt(3);
      presetn <= 1'h1;
      xfer(1'h1, ADDR_CTRL, 32'h1);
      for (int i = 0; i < 13; i++) begin
         cond_in <= cond_t'(13'h1000 >> i);
         wt(5);
         chk("code", 32'(row_code[i]), 32'(host_code));
         chk("active", 32'h1, 32'(warning_active));
      end
      cond_in <= cond_t'(13'h1004);
      wt(5);
      chk("prio", 32'(CODE_LHH), 32'(host_code));
      xfer(1'h1, ADDR_CTRL, 32'h3);
      wt(5);
      chk("nodet", 32'(CODE_LLL), 32'(host_code));
      chk("uv", 32'h1, 32'(warning_active));
      cond_in <= cond_t'(13'h1000);
      wt(5);
      chk("supp", 32'h0, 32'(warning_active));
      xfer(1'h1, ADDR_CTRL, 32'h0);
      wt(5);
      chk("sel", 32'h0, 32'(host_code));
      cond_in <= '0;
      xfer(1'h1, ADDR_CTRL, 32'h1);
      xfer(1'h1, ADDR_DEV_LVL, {8'h32, 24'h3E8});
      position_deviation <= 32'h1F4;
      wt(5);
      chk("dev_edge", 32'h0, 32'(warning_active));
      position_deviation <= 32'h1F5;
      wt(3);
      chk("dev", 32'(CODE_HHH), 32'(host_code));
      servo_on <= 1'h0;
      xfer(1'h1, ADDR_SON_LVL, {8'h64, 24'h64});
      position_deviation <= 32'hC8;
      servo_on <= 1'h1;
      wt(5);
      xfer(1'h0, ADDR_WARN, 32'h0);
      chk("son", 32'h1, 32'(rd[W_SON]));
      position_deviation <= '0;
      ut(32'h4);
      vib_detect <= 1'h1;
      wt(5);
      chk("vib_warn", 32'(CODE_LHH), 32'(host_code));
      xfer(1'h1, ADDR_CTRL, 32'h5);
      wt(5);
      chk("vib_alarm", 32'h1, 32'(vibration_alarm));
      vib_detect <= 1'h0;
      ut(32'h4);
      chk("vib_clr", 32'h0, 32'(vibration_alarm));
      option_in.model_bad <= 4'h1;
      wt(5);
      chk("opt", 32'h1, 32'(option_alarm));
      option_in.model_bad <= '0;
      ut(32'h4);
      chk("opt_keep", 32'h1, 32'(option_alarm));
      xfer(1'h1, ADDR_CTRL, 32'h8);
      ut(32'h1);
      chk("opt_prot", 32'h1, 32'(option_alarm));
      xfer(1'h1, ADDR_CTRL, 32'h0);
      ut(32'h1);
      chk("opt_clr", 32'h0, 32'(option_alarm));
      option_in.hw_error <= 4'h1;
      wt(6);
      ut(32'h1);
      chk("hw_err", 32'h1, 32'(option_alarm));
      option_in.hw_error <= '0;
      xfer(1'h0, 8'h20, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      chk("rd_bad", 32'h0, rd);
      motor_type <= 8'h09;
      stored_opt_alarm <= 1'h1;
      presetn <= 1'h0;
      wt(2);
      presetn <= 1'h1;
      wt(4);
      chk("mtype", 32'h1, 32'(motor_type_alarm));
      chk("opt_pwr", 32'h1, 32'(option_alarm));
      chk("mt_load", 32'h5, 32'(motor_type_save));
      ut(32'h4);
      chk("mt_keep", 32'h1, 32'(motor_type_alarm));
      xfer(1'h1, ADDR_CTRL, 32'h8);
      ut(32'h2);
      chk("mt_prot", 32'h1, 32'(motor_type_alarm));
      xfer(1'h1, ADDR_CTRL, 32'h0);
      ut(32'h2);
      chk("mt_clr", 32'h0, 32'(motor_type_alarm));
      chk("mt_save", 32'h9, 32'(motor_type_save));
      stored_motor_type <= 8'h09;
      for (int k = 0; k < 2; k++) begin
         stored_mtype_alarm <= k[0];
         presetn <= 1'h0;
         wt(2);
         presetn <= 1'h1;
         wt(4);
         chk("mt_start", 32'(k), 32'(motor_type_alarm));
      end
      end_sim;
   end
endmodule
